// ==== i2c_status_pkg.sv ====
// Shared constants and carriers for the two-wire status and clock block
package i2c_status_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int DIV_W = 12;
   localparam int RISE_W = 6;
   localparam int PEC_W = 8;
   localparam int CNT_W = 17;
   localparam int FIFO_DEPTH = 4;

   localparam logic [ADDR_W-1:0] OFS_STATUS2 = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_CLKCFG = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_RISE = 12'h008;

   localparam int PEC_LSB = 8;
   localparam int DUAL_BIT = 7;
   localparam int HOST_BIT = 6;
   localparam int DEFAULT_BIT = 5;
   localparam int GCALL_BIT = 4;
   localparam int DIR_BIT = 2;
   localparam int BUSY_BIT = 1;
   localparam int MASTER_BIT = 0;
   localparam int FAST_BIT = 15;
   localparam int DUTY_BIT = 14;
   localparam int DIV_LSB = 0;
   localparam int RISE_LSB = 0;

   localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
   localparam logic [RISE_W-1:0] RISE_RESET = 6'h02;

   // High and low phase lengths in divider units
   localparam logic [CNT_W-1:0] STD_HI_MUL = 17'h00001;
   localparam logic [CNT_W-1:0] STD_LO_MUL = 17'h00001;
   localparam logic [CNT_W-1:0] F33_HI_MUL = 17'h00001;
   localparam logic [CNT_W-1:0] F33_LO_MUL = 17'h00002;
   localparam logic [CNT_W-1:0] F36_HI_MUL = 17'h00009;
   localparam logic [CNT_W-1:0] F36_LO_MUL = 17'h00010;

   typedef struct packed {
      logic rw_bit;
      logic second_match;
      logic host_header;
      logic default_addr;
      logic general_call;
   } addr_rec_s;

   typedef enum logic [1:0] {gen_idle, gen_low, gen_rise, gen_high} scl_gen_e;
endpackage : i2c_status_pkg

// ==== i2c_status_clock_regs.sv ====
// Status word two, clock config and rise limit registers with SCL generator
//
// Notes on behaviour
// - Status bits 15:8 show the packet check value when checking enabled; read only.
// - Bit 7 set on match with second own address, cleared on first.
// - Bit 6 set on host address when host role and address resolution enabled.
// - Bit 5 set on device default address when address resolution enabled.
// - Bit 4 set on general call address when general call enabled.
// - Address flags cleared on generated start or stop, or interface off.
// - Bit 2 follows the read/write bit of the address byte.
// - Direction cleared on stop, repeated start, lost arbitration, or interface off.
// - Bit 1 busy while SDA or SCL low, cleared on detected stop.
// - Busy keeps following the bus lines while interface off.
// - Bit 0 set after start sent as master; cleared on stop, arbitration loss, off.
// - Bit 15 picks fast mode; bit 14 picks 36 or 33.3 percent high.
// - Twelve bit SCL divider in bits 11:0, reset zero.
// - Six bit rise limit in bits 5:0, reset two.
// - Rise limit writes accepted only while the interface is off.
// - Rise limit is the longest SCL rise time in clock periods.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module addr_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 4
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } fifo_s;

   fifo_s st;
   fifo_s next_st;
   logic push, pop;
   assign in_ready_out = (st.cnt != CW'(DEPTH));
   assign out_valid_out = (st.cnt != '0);
   assign out_data_out = st.mem[st.rp];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wp] = in_data_in;
         next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : PW'(st.wp + 1'b1);
      end
      if (pop) begin
         next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : PW'(st.rp + 1'b1);
      end
      next_st.cnt = CW'(st.cnt + CW'(push) - CW'(pop));
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking fifo_cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   chk_fifo_no_overfill: assert property (!in_ready_out && !pop |=> st.cnt == CW'(DEPTH))
      else $error("fifo count moved while full without a pop");
   cov_fifo_full: cover property (out_valid_out && !in_ready_out);
endmodule : addr_fifo

module i2c_status_clock_regs (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [i2c_status_pkg::ADDR_W-1:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [i2c_status_pkg::DATA_W-1:0] pwdata_in,
   output logic [i2c_status_pkg::DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic interface_on_in,
   input wire logic packet_check_enable_in,
   input wire logic [i2c_status_pkg::PEC_W-1:0] packet_check_value_in,
   input wire logic arp_enable_in,
   input wire logic smbus_role_select_in,
   input wire logic general_call_enable_in,
   input wire logic addr_valid_in,
   input wire i2c_status_pkg::addr_rec_s addr_rec_in,
   output logic addr_ready_out,
   input wire logic start_sent_in,
   input wire logic start_gen_in,
   input wire logic stop_gen_in,
   input wire logic arb_lost_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe_n_out
);
   typedef struct packed {
      logic [2:0] sync_scl;
      logic [2:0] sync_sda;
      logic busy;
      logic master;
      logic dir;
      logic dual;
      logic host;
      logic dflt;
      logic gcall;
      logic fast;
      logic duty;
      logic [i2c_status_pkg::DIV_W-1:0] div;
      logic [i2c_status_pkg::RISE_W-1:0] rise;
      logic [i2c_status_pkg::DATA_W-1:0] rdata;
      logic err;
      i2c_status_pkg::scl_gen_e gen;
      logic [i2c_status_pkg::CNT_W-1:0] cnt;
      logic scl_oe_n;
   } state_s;
   state_s st;
   state_s next_st;
   i2c_status_pkg::addr_rec_s rec;
   logic rec_valid, rec_take, run;
   logic scl_now, scl_prev, sda_now, sda_prev, start_det, stop_det;
   logic flag_clr, dir_clr, setup, access_wr, hit_status, hit_clk, hit_rise;
   logic [i2c_status_pkg::PEC_W-1:0] pec_view;
   logic [i2c_status_pkg::DATA_W-1:0] status_word, clk_word, rise_word;
   logic [i2c_status_pkg::CNT_W-1:0] div_w, hi_len, lo_len;
   // Address events queue here while the interface is off, pushing back on the matcher
   addr_fifo #(
      .WIDTH($bits(i2c_status_pkg::addr_rec_s)),
      .DEPTH(i2c_status_pkg::FIFO_DEPTH)
   ) u_addr_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(addr_valid_in),
      .in_ready_out(addr_ready_out),
      .in_data_in(addr_rec_in),
      .out_valid_out(rec_valid),
      .out_ready_in(interface_on_in),
      .out_data_out(rec)
   );

   assign rec_take = rec_valid & interface_on_in;
   // Only the second and third stages feed the detectors
   assign scl_now = st.sync_scl[1];
   assign scl_prev = st.sync_scl[2];
   assign sda_now = st.sync_sda[1];
   assign sda_prev = st.sync_sda[2];
   assign start_det = scl_now & scl_prev & sda_prev & ~sda_now;
   assign stop_det = scl_now & scl_prev & ~sda_prev & sda_now;

   assign flag_clr = ~interface_on_in | start_gen_in | stop_gen_in;
   assign dir_clr = stop_det | (start_det & st.busy) | arb_lost_in | ~interface_on_in;
   assign setup = psel_in & ~penable_in;
   assign access_wr = psel_in & penable_in & pwrite_in & ~st.err;
   assign hit_status = (paddr_in == i2c_status_pkg::OFS_STATUS2);
   assign hit_clk = (paddr_in == i2c_status_pkg::OFS_CLKCFG);
   assign hit_rise = (paddr_in == i2c_status_pkg::OFS_RISE);

   assign pec_view = packet_check_enable_in ? packet_check_value_in : '0;
   always_comb begin
      status_word = '0;
      status_word[i2c_status_pkg::PEC_LSB +: i2c_status_pkg::PEC_W] = pec_view;
      status_word[i2c_status_pkg::DUAL_BIT] = st.dual;
      status_word[i2c_status_pkg::HOST_BIT] = st.host;
      status_word[i2c_status_pkg::DEFAULT_BIT] = st.dflt;
      status_word[i2c_status_pkg::GCALL_BIT] = st.gcall;
      status_word[i2c_status_pkg::DIR_BIT] = st.dir;
      status_word[i2c_status_pkg::BUSY_BIT] = st.busy;
      status_word[i2c_status_pkg::MASTER_BIT] = st.master;
      clk_word = '0;
      clk_word[i2c_status_pkg::FAST_BIT] = st.fast;
      clk_word[i2c_status_pkg::DUTY_BIT] = st.duty;
      clk_word[i2c_status_pkg::DIV_LSB +: i2c_status_pkg::DIV_W] = st.div;
      rise_word = '0;
      rise_word[i2c_status_pkg::RISE_LSB +: i2c_status_pkg::RISE_W] = st.rise;
   end

   // Phase lengths; the widest product still fits the counter
   assign div_w = i2c_status_pkg::CNT_W'(st.div);
   always_comb begin
      if (!st.fast) begin
         hi_len = i2c_status_pkg::CNT_W'(div_w * i2c_status_pkg::STD_HI_MUL);
         lo_len = i2c_status_pkg::CNT_W'(div_w * i2c_status_pkg::STD_LO_MUL);
      end else if (st.duty) begin
         hi_len = i2c_status_pkg::CNT_W'(div_w * i2c_status_pkg::F36_HI_MUL);
         lo_len = i2c_status_pkg::CNT_W'(div_w * i2c_status_pkg::F36_LO_MUL);
      end else begin
         hi_len = i2c_status_pkg::CNT_W'(div_w * i2c_status_pkg::F33_HI_MUL);
         lo_len = i2c_status_pkg::CNT_W'(div_w * i2c_status_pkg::F33_LO_MUL);
      end
   end

   assign run = st.master & interface_on_in & (st.div != '0);
   always_comb begin
      next_st = st;
      next_st.sync_scl = {st.sync_scl[1:0], scl_in};
      next_st.sync_sda = {st.sync_sda[1:0], sda_in};

      // Ignores the enable on purpose so software sees the bus before turning on
      next_st.busy = stop_det ? 1'b0 : (st.busy | ~scl_now | ~sda_now);

      if (flag_clr) begin
         next_st.dual = 1'b0;
         next_st.host = 1'b0;
         next_st.dflt = 1'b0;
         next_st.gcall = 1'b0;
      end
      // A record taken in a clearing cycle still lands
      if (rec_take) begin
         next_st.dual = rec.second_match;
         next_st.host = next_st.host | (rec.host_header & smbus_role_select_in
                        & arp_enable_in);
         next_st.dflt = next_st.dflt | (rec.default_addr & arp_enable_in);
         next_st.gcall = next_st.gcall | (rec.general_call & general_call_enable_in);
      end

      if (dir_clr) begin
         next_st.dir = 1'b0;
      end
      if (rec_take) begin
         next_st.dir = rec.rw_bit;
      end

      if (stop_det | arb_lost_in | ~interface_on_in) begin
         next_st.master = 1'b0;
      end
      if (start_sent_in & interface_on_in) begin
         next_st.master = 1'b1;
      end

      if (setup) begin
         next_st.err = ~(hit_status | hit_clk | hit_rise);
         next_st.rdata = hit_status ? status_word :
                         hit_clk ? clk_word :
                         hit_rise ? rise_word : '0;
      end
      if (access_wr & hit_clk) begin
         next_st.fast = pwdata_in[i2c_status_pkg::FAST_BIT];
         next_st.duty = pwdata_in[i2c_status_pkg::DUTY_BIT];
         next_st.div = pwdata_in[i2c_status_pkg::DIV_LSB +: i2c_status_pkg::DIV_W];
      end
      if (access_wr & hit_rise & ~interface_on_in) begin
         next_st.rise = pwdata_in[i2c_status_pkg::RISE_LSB +: i2c_status_pkg::RISE_W];
      end

      if (!run) begin
         next_st.gen = i2c_status_pkg::gen_idle;
         next_st.cnt = '0;
         next_st.scl_oe_n = 1'b1;
      end else begin
         case (st.gen)
            i2c_status_pkg::gen_idle: begin
               next_st.gen = i2c_status_pkg::gen_low;
               next_st.cnt = '0;
               next_st.scl_oe_n = 1'b0;
            end
            i2c_status_pkg::gen_low: begin
               if (i2c_status_pkg::CNT_W'(st.cnt + 1'b1) >= lo_len) begin
                  next_st.gen = i2c_status_pkg::gen_rise;
                  next_st.cnt = '0;
                  next_st.scl_oe_n = 1'b1;
               end else begin
                  next_st.cnt = i2c_status_pkg::CNT_W'(st.cnt + 1'b1);
               end
            end
            i2c_status_pkg::gen_rise: begin
               // High phase starts once SCL is seen high or the rise budget runs out
               if (scl_now || st.cnt >= i2c_status_pkg::CNT_W'(st.rise)) begin
                  next_st.gen = i2c_status_pkg::gen_high;
                  next_st.cnt = '0;
               end else begin
                  next_st.cnt = i2c_status_pkg::CNT_W'(st.cnt + 1'b1);
               end
            end
            i2c_status_pkg::gen_high: begin
               if (i2c_status_pkg::CNT_W'(st.cnt + 1'b1) >= hi_len) begin
                  next_st.gen = i2c_status_pkg::gen_low;
                  next_st.cnt = '0;
                  next_st.scl_oe_n = 1'b0;
               end else begin
                  next_st.cnt = i2c_status_pkg::CNT_W'(st.cnt + 1'b1);
               end
            end
            default: begin
               next_st.gen = i2c_status_pkg::gen_idle;
               next_st.cnt = '0;
               next_st.scl_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
         st.sync_scl <= 3'h7;
         st.sync_sda <= 3'h7;
         st.div <= i2c_status_pkg::DIV_RESET;
         st.rise <= i2c_status_pkg::RISE_RESET;
         st.gen <= i2c_status_pkg::gen_idle;
         st.scl_oe_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Zero wait state; status writes fall through harmlessly
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in & penable_in & st.err;
   assign prdata_out = st.rdata;
   assign scl_out = 1'b0;
   assign scl_oe_n_out = st.scl_oe_n;

   default clocking top_cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   chk_rise_locked: assert property (access_wr && hit_rise && interface_on_in |=> $stable(st.rise))
      else $error("rise limit changed while interface on");
   chk_div_write: assert property (access_wr && hit_clk |=> st.div == $past(pwdata_in[11:0]))
      else $error("divider did not take written value");
   chk_busy_stop: assert property (stop_det |=> !st.busy)
      else $error("busy not cleared after stop");
   chk_busy_line_low: assert property (!scl_now && !stop_det |=> st.busy)
      else $error("busy not set with SCL low");
   chk_master_set: assert property (start_sent_in && interface_on_in |=> st.master)
      else $error("master flag not set after start sent");
   chk_master_off: assert property (!interface_on_in |=> !st.master)
      else $error("master flag survived interface off");
   chk_dir_clear: assert property (dir_clr && !rec_take |=> !st.dir)
      else $error("direction flag not cleared");
   chk_flags_off: assert property (!interface_on_in |=> !(st.dual | st.host | st.dflt | st.gcall))
      else $error("address flags survived interface off");
   chk_gcall_gate: assert property (rec_take && !general_call_enable_in && !st.gcall |=> !st.gcall)
      else $error("general call flag set while disabled");
   chk_pec_read: assert property (setup && hit_status |=> prdata_out[15:8] == $past(pec_view))
      else $error("packet check byte wrong on read");
   chk_reserved_zero: assert property (psel_in && penable_in && !pwrite_in && !st.err
                                       |-> prdata_out[31:16] == 16'h0000)
      else $error("reserved bits read nonzero");
   chk_high_bound: assert property (st.gen == i2c_status_pkg::gen_high && run |-> st.cnt < hi_len)
      else $error("high phase ran past its length");

   cov_addr_taken: cover property (rec_take && rec.second_match);
   cov_rise_write: cover property (access_wr && hit_rise && !interface_on_in);
   cov_scl_cycle: cover property (st.gen == i2c_status_pkg::gen_high ##1 st.gen == i2c_status_pkg::gen_low);
   cov_repeat_start: cover property (start_det && st.busy);
endmodule : i2c_status_clock_regs

// ==== i2c_far_side.sv ====
// Far-side bus device model: open-drain lines with pull-ups and clock stretching
`timescale 1ns/1ps
module i2c_far_side (
   input wire logic link_clk_in,
   input wire logic scl_out_in,
   input wire logic scl_oe_n_in,
   output logic scl_line_out,
   output logic sda_line_out
);
   int stretch = 0;
   logic scl_hold = 1'h0;
   logic stretch_low = 1'h0;
   logic sda_low = 1'h0;
   logic dut_low;
   assign dut_low = (scl_oe_n_in == 1'h0) && (scl_out_in == 1'h0);
   // Released lines float to the pull-up level, never to a stale value
   assign scl_line_out = !(dut_low || scl_hold || stretch_low);
   assign sda_line_out = !sda_low;
   // Slow answer: keep SCL low some link periods after the master lets go
   always @(negedge dut_low) begin
      if (stretch > 0) begin
         stretch_low = 1'h1;
         repeat (stretch) @(posedge link_clk_in);
         stretch_low = 1'h0;
      end
   end
   // Start: SDA falls while SCL is high, then SCL is pulled low
   task automatic start_cond();
      @(posedge link_clk_in);
      sda_low <= 1'h1;
      @(posedge link_clk_in);
      scl_hold <= 1'h1;
   endtask : start_cond
   // Stop: SCL released first, then SDA rises while SCL is high
   task automatic stop_cond();
      @(posedge link_clk_in);
      scl_hold <= 1'h0;
      @(posedge link_clk_in);
      sda_low <= 1'h0;
   endtask : stop_cond
endmodule : i2c_far_side

// ==== tb.sv ====
// Self-checking bench for the status, clock config and rise limit registers
`timescale 1ns/1ps
module tb;
   logic clk_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, addr_ready, scl_out, scl_oe_n, scl_line, sda_line;
   logic on = 1'h0, pce = 1'h0, arp = 1'h0, role = 1'h0, gce = 1'h0, avalid = 1'h0;
   logic [7:0] packet_check_value = 8'h00;
   logic [3:0] ev = 4'h0;
   i2c_status_pkg::addr_rec_s rec = '0;
   i2c_status_pkg::addr_rec_s r;
   logic link_clk = 1'h0;
   logic frame_on = 1'h0;
   int failures = 0;
   int samples_checked = 0;
   integer seed = 32'h8b13a968;
   logic [31:0] rd, exp;
   logic err;
   int n;

   i2c_status_clock_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .interface_on_in(on), .packet_check_enable_in(pce), .packet_check_value_in(packet_check_value),
      .arp_enable_in(arp), .smbus_role_select_in(role), .general_call_enable_in(gce),
      .addr_valid_in(avalid), .addr_rec_in(rec), .addr_ready_out(addr_ready),
      .start_sent_in(ev[0]), .start_gen_in(ev[1]), .stop_gen_in(ev[2]), .arb_lost_in(ev[3]),
      .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out), .scl_oe_n_out(scl_oe_n));
   i2c_far_side far (.link_clk_in(link_clk), .scl_out_in(scl_out), .scl_oe_n_in(scl_oe_n),
      .scl_line_out(scl_line), .sda_line_out(sda_line));

   always #2 clk_in = ~clk_in;
   // Link clock is offset in phase and stands still outside frames
   initial begin
      #1.7;
      forever begin
         #40;
         link_clk = frame_on ? ~link_clk : 1'h0;
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask : chk

   task automatic idle(input int k);
      repeat (k) @(posedge clk_in);
   endtask : idle

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge clk_in);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'h1;
      t = 0;
      do begin
         @(posedge clk_in);
         t++;
      end while (pready !== 1'h1 && t < 50);
      rd = prdata;
      err = pslverr;
      if (t >= 50) failures++;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] e,
         input logic [31:0] m);
      apb(1'h0, a, 32'h0);
      chk(name, e & m, rd & m);
   endtask : rchk

   task automatic pulse(input logic [3:0] m);
      @(posedge clk_in);
      ev <= m;
      @(posedge clk_in);
      ev <= 4'h0;
   endtask : pulse

   task automatic push(input i2c_status_pkg::addr_rec_s v);
      int t;
      @(posedge clk_in);
      avalid <= 1'h1;
      rec <= v;
      t = 0;
      do begin
         @(posedge clk_in);
         t++;
      end while (addr_ready !== 1'h1 && t < 50);
      if (t >= 50) failures++;
      avalid <= 1'h0;
   endtask : push

   // Length of the next full SCL low phase, in clock cycles
   task automatic low_len(output int k);
      int t;
      t = 0;
      while (scl_oe_n !== 1'h1 && t < 4000) begin
         @(posedge clk_in);
         t++;
      end
      while (scl_oe_n !== 1'h0 && t < 4000) begin
         @(posedge clk_in);
         t++;
      end
      k = 0;
      while (scl_oe_n === 1'h0 && t < 4000) begin
         @(posedge clk_in);
         t++;
         k++;
      end
   endtask : low_len

   function automatic logic [31:0] flg(input i2c_status_pkg::addr_rec_s v,
         input logic [31:0] p);
      logic [31:0] f;
      f = p & 32'h00000070;
      f[i2c_status_pkg::DUAL_BIT] = v.second_match;
      f[i2c_status_pkg::HOST_BIT] = f[i2c_status_pkg::HOST_BIT] | (v.host_header & role & arp);
      f[i2c_status_pkg::DEFAULT_BIT] = f[i2c_status_pkg::DEFAULT_BIT] | (v.default_addr & arp);
      f[i2c_status_pkg::GCALL_BIT] = f[i2c_status_pkg::GCALL_BIT] | (v.general_call & gce);
      f[i2c_status_pkg::DIR_BIT] = v.rw_bit;
      return f;
   endfunction : flg

   initial begin
      #300000;
      failures++;
      print_verdict();
   end

   initial begin
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'h1;
      rchk("status reset", i2c_status_pkg::OFS_STATUS2, 32'h0, 32'hffffffff);
      rchk("clkcfg reset", i2c_status_pkg::OFS_CLKCFG, 32'h0, 32'hffffffff);
      rchk("rise reset", i2c_status_pkg::OFS_RISE, 32'h2, 32'hffffffff);
      for (int i = 0; i < 5; i++) begin
         exp = (i == 0) ? 32'hffffffff : 32'($random(seed));
         apb(1'h1, i2c_status_pkg::OFS_CLKCFG, exp);
         rchk("clkcfg", i2c_status_pkg::OFS_CLKCFG, exp & 32'h0000cfff, 32'hffffffff);
      end
      on <= 1'h1;
      apb(1'h1, i2c_status_pkg::OFS_RISE, 32'h0000003f);
      rchk("rise while on", i2c_status_pkg::OFS_RISE, 32'h2, 32'hffffffff);
      on <= 1'h0;
      exp = 32'($random(seed));
      apb(1'h1, i2c_status_pkg::OFS_RISE, exp);
      rchk("rise while off", i2c_status_pkg::OFS_RISE, exp & 32'h3f, 32'hffffffff);
      apb(1'h1, i2c_status_pkg::OFS_STATUS2, 32'hffffffff);
      rchk("status write", i2c_status_pkg::OFS_STATUS2, 32'h0, 32'hffffffff);
      apb(1'h0, 12'h00c, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      on <= 1'h1;
      pce <= 1'h1;
      exp = 32'($random(seed));
      packet_check_value <= exp[7:0];
      rchk("pec", i2c_status_pkg::OFS_STATUS2, {16'h0, exp[7:0], 8'h0}, 32'hff00);
      pce <= 1'h0;
      rchk("pec disabled", i2c_status_pkg::OFS_STATUS2, 32'h0, 32'hff00);
      for (int i = 0; i < 16; i++) begin
         {arp, role, gce} <= (i == 0) ? 3'h7 : 3'($random(seed));
         r = (i == 0) ? 5'h1f : 5'($random(seed));
         pulse(i[0] ? 4'hc : 4'ha);
         push(r);
         idle(4);
         rchk("addr flags", i2c_status_pkg::OFS_STATUS2, flg(r, 0), 32'hf4);
      end
      push(5'h1f);
      idle(4);
      pulse(4'h8);
      idle(3);
      rchk("dir arb lost", i2c_status_pkg::OFS_STATUS2, 32'h0, 32'h4);
      push(5'h1f);
      idle(4);
      on <= 1'h0;
      idle(3);
      rchk("flags off", i2c_status_pkg::OFS_STATUS2, 32'h0, 32'hf4);
      // Fill the queue while off; records must wait until turned on
      exp = 32'h0;
      for (int i = 0; i < 4; i++) begin
         r = 5'($random(seed));
         exp = flg(r, exp);
         push(r);
      end
      idle(1);
      chk("queue full", 32'h0, {31'h0, addr_ready});
      rchk("held while off", i2c_status_pkg::OFS_STATUS2, 32'h0, 32'hf4);
      on <= 1'h1;
      idle(10);
      chk("queue empty", 32'h1, {31'h0, addr_ready});
      rchk("drained flags", i2c_status_pkg::OFS_STATUS2, exp, 32'hf4);
      for (int k = 0; k < 2; k++) begin
         on <= k[0];
         frame_on <= 1'h1;
         far.start_cond();
         if (k == 1) push(5'h10);
         idle(8);
         rchk("busy", i2c_status_pkg::OFS_STATUS2, (k == 1) ? 32'h6 : 32'h2, 32'h6);
         far.stop_cond();
         frame_on <= 1'h0;
         idle(8);
         rchk("idle", i2c_status_pkg::OFS_STATUS2, 32'h0, 32'h6);
      end
      apb(1'h1, i2c_status_pkg::OFS_CLKCFG, 32'h3);
      pulse(4'h1);
      idle(2);
      rchk("master set", i2c_status_pkg::OFS_STATUS2, 32'h1, 32'h1);
      frame_on <= 1'h1;
      for (int m = 0; m < 3; m++) begin
         apb(1'h1, i2c_status_pkg::OFS_CLKCFG, (m == 0) ? 32'h3 : ((m == 1) ? 32'h8003 : 32'hc003));
         far.stretch = m;
         low_len(n);
         low_len(n);
         chk("scl low", (m == 0) ? 32'd3 : ((m == 1) ? 32'd6 : 32'd48), 32'(n));
         chk("scl drive level", 32'h0, {31'h0, scl_out});
      end
      frame_on <= 1'h0;
      pulse(4'h8);
      idle(3);
      rchk("master arb lost", i2c_status_pkg::OFS_STATUS2, 32'h0, 32'h1);
      print_verdict();
   end
endmodule : tb
